// >>> hdl/ltf_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltf_regs.svh"
module ltf_top
    import ltf_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `LTF_DEBOUNCE_MS * `LTF_CLK_KHZ,
    parameter int FAULT_CYC = `LTF_FAULT_MS * `LTF_CLK_KHZ,
    parameter bit PWM_INVERT = 1'b0
)
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic toggle_n_i,
    input wire logic pwm_i,
    input wire logic short_detect_i,
    input wire logic supply_low_i,
    input wire logic [11:0] fade_in_time_set_i,
    input wire logic [11:0] fade_out_time_set_i,
    output logic [9:0] drive_level_o,
    output logic latched_on_o,
    output logic fault_o,
    output logic pwm_mode_o
);
    // cycles per gamma step: per millisecond of fade, and for instant fade
    localparam logic [23:0] STEP_PER_MS =
        24'(`LTF_CLK_KHZ / `LTF_STEPS);
    localparam logic [23:0] INSTANT_STEP =
        24'(`LTF_INSTANT_NS / `LTF_CLK_NS / `LTF_STEPS);
    localparam logic [23:0] DEB_LAST = 24'(DEBOUNCE_CYC - 1);
    localparam logic [23:0] FLT_LAST = 24'(FAULT_CYC - 1);

    logic [1:0] tog_sync_q, pwm_sync_q, sc_sync_q, sup_sync_q;
    logic tog_stable_q;
    logic [23:0] tog_cnt_q;
    logic press;
    logic short_q;
    logic [23:0] flt_cnt_q;
    ltf_state_t state_q, state_d;
    ltf_idx_t idx_q, idx_d;
    logic lamp_on_q;
    logic [23:0] step_cnt_q, step_len;
    logic step_tick;
    logic pwm_on;
    ltf_level_t level_d, base_level;
    ltf_gamma_if gamma_if ();

    // two-flop synchronisers; toggle idles released (high)
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            tog_sync_q <= 2'h3;
            pwm_sync_q <= 2'h0;
            sc_sync_q <= 2'h0;
            sup_sync_q <= 2'h0;
        end
        else
        begin
            tog_sync_q <= {tog_sync_q[0], toggle_n_i};
            pwm_sync_q <= {pwm_sync_q[0], pwm_i};
            sc_sync_q <= {sc_sync_q[0], short_detect_i};
            sup_sync_q <= {sup_sync_q[0], supply_low_i};
        end
    end

    // debounce: any change restarts the count, both edges alike
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            tog_stable_q <= 1'b1;
            tog_cnt_q <= 24'h0;
        end
        else if (tog_sync_q[1] == tog_stable_q)
            tog_cnt_q <= 24'h0;
        else if (tog_cnt_q == DEB_LAST)
        begin
            tog_stable_q <= tog_sync_q[1];
            tog_cnt_q <= 24'h0;
        end
        else
            tog_cnt_q <= tog_cnt_q + 24'h1;
    end
    // a press is an accepted high-to-low change
    assign press = (tog_sync_q[1] != tog_stable_q) && !tog_sync_q[1]
        && (tog_cnt_q == DEB_LAST);

    // short fault persistence filter, clears at once
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !sc_sync_q[1])
        begin
            short_q <= 1'b0;
            flt_cnt_q <= 24'h0;
        end
        else if (!short_q && flt_cnt_q == FLT_LAST)
            short_q <= 1'b1;
        else if (!short_q)
            flt_cnt_q <= flt_cnt_q + 24'h1;
    end

    // toggle latch
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || sup_sync_q[1])
            lamp_on_q <= 1'b0;
        else if (press)
            lamp_on_q <= !lamp_on_q;
    end

    // step interval for the current direction, zero setting is instant
    always_comb
    begin
        if (lamp_on_q)
            step_len = (fade_in_time_set_i == 12'h0) ? INSTANT_STEP :
                24'(fade_in_time_set_i * STEP_PER_MS);
        else
            step_len = (fade_out_time_set_i == 12'h0) ? INSTANT_STEP :
                24'(fade_out_time_set_i * STEP_PER_MS);
    end
    assign step_tick = (step_cnt_q >= step_len - 24'h1);

    // step timer restarts on every press or idle state
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || press || step_tick)
            step_cnt_q <= 24'h0;
        else if (state_q == LTF_UP || state_q == LTF_DOWN)
            step_cnt_q <= step_cnt_q + 24'h1;
        else
            step_cnt_q <= 24'h0;
    end

    // ramp state and index; direction follows the latch
    always_comb
    begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            LTF_OFF:
                if (lamp_on_q)
                    state_d = LTF_UP;
            LTF_UP:
                if (!lamp_on_q)
                    state_d = LTF_DOWN;
                else if (idx_q == `LTF_LAST_IDX)
                    state_d = LTF_ON;
                else if (step_tick)
                    idx_d = idx_q + 6'h1;
            LTF_ON:
                if (!lamp_on_q)
                    state_d = LTF_DOWN;
            LTF_DOWN:
                if (lamp_on_q)
                    state_d = LTF_UP;
                else if (idx_q == 6'h0)
                    state_d = LTF_OFF;
                else if (step_tick)
                    idx_d = idx_q - 6'h1;
            default:
                state_d = LTF_OFF;
        endcase
        if (sup_sync_q[1])
        begin
            state_d = LTF_OFF;
            idx_d = 6'h0;
        end
    end

    // ramp registers
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_q <= LTF_OFF;
            idx_q <= 6'h0;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    // table address runs on the next index so its output matches idx_q
    assign gamma_if.idx = idx_d;
    ltf_gamma_rom u_rom (
        .mclk_i(mclk_i),
        .port_io(gamma_if)
    );

    // pwm honoured only when idle off; positive polarity by default
    assign pwm_on = pwm_sync_q[1] ^ PWM_INVERT;
    always_comb
    begin
        if (state_q == LTF_OFF)
            base_level = pwm_on ? `LTF_FULL_SCALE : 10'h0;
        else
            base_level = gamma_if.level;
        level_d = short_q ? 10'(base_level / `LTF_FAULT_DIV) : base_level;
    end

    // output registers
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            drive_level_o <= 10'h0;
            pwm_mode_o <= 1'b0;
        end
        else
        begin
            drive_level_o <= level_d;
            pwm_mode_o <= (state_q == LTF_OFF);
        end
    end
    assign latched_on_o = lamp_on_q;
    assign fault_o = short_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    power_up_off_a: assert property (
        $past(reset_i) |-> state_q == LTF_OFF && drive_level_o == 10'h0)
        else $error("not off after reset");
    press_toggles_a: assert property (
        press && !sup_sync_q[1] |=> lamp_on_q != $past(lamp_on_q))
        else $error("press did not toggle latch");
    debounce_hold_a: assert property (
        $changed(tog_stable_q) |-> $past(tog_cnt_q) == DEB_LAST
            && $past(tog_sync_q[1]) == tog_stable_q)
        else $error("level accepted before window");
    step_up_a: assert property (
        state_q == LTF_UP && lamp_on_q && step_tick
            && idx_q != `LTF_LAST_IDX && !sup_sync_q[1]
        |=> idx_q == $past(idx_q) + 6'h1)
        else $error("ramp step missed");
    idx_range_a: assert property (
        idx_q <= `LTF_LAST_IDX)
        else $error("step index past last step");
    pwm_bypass_a: assert property (
        state_q == LTF_OFF && !short_q
        |=> drive_level_o == ($past(pwm_on) ? `LTF_FULL_SCALE : 10'h0))
        else $error("pwm level not passed through");
    pwm_ignored_a: assert property (
        state_q == LTF_ON && !short_q |=> drive_level_o == `LTF_FULL_SCALE)
        else $error("latched on level disturbed");
    fault_persist_a: assert property (
        $rose(short_q) |-> $past(flt_cnt_q) == FLT_LAST
            && $past(sc_sync_q[1]))
        else $error("fault declared too early");
    fault_reduce_a: assert property (
        state_q == LTF_ON && short_q |=> drive_level_o == 10'd200)
        else $error("fault level not one fifth");
    supply_loss_a: assert property (
        sup_sync_q[1] |=> !lamp_on_q && idx_q == 6'h0)
        else $error("latch kept on supply loss");
    instant_fade_a: assert property (
        $past(lamp_on_q) && $past(fade_in_time_set_i) == 12'h0
        |-> step_cnt_q < INSTANT_STEP)
        else $error("zero fade setting not instant");
endmodule : ltf_top
`default_nettype wire

// >>> hdl/ltf_regs.svh
// Notes on behaviour
// - input stable 25-50 ms before accepted
// - rise and fall debounced the same way
// - powers up latched off, zero current
// - press when off latches on, fades in
// - press when on latches off, fades out
// - ramps use 63 gamma steps
// - press mid-ramp reverses the ramp
// - honoured PWM bypasses gamma and fades
// - PWM ignored while latched on
// - press toggles even while PWM active
// - PWM duty sets average current linearly
// - short fault after 5 ms persistence
// - positive polarity PWM, no inversion
// - floating toggle input reads as released
// - zero fade setting gives 70 us switch
// - fixed 63-entry gamma table 0 to 1000
// - supply loss resets latch to off
// - short fault cuts current to 20 percent
`ifndef LTF_REGS_SVH
`define LTF_REGS_SVH
`define LTF_CLK_KHZ 125000
`define LTF_DEBOUNCE_MS 37
`define LTF_FAULT_MS 5
`define LTF_INSTANT_NS 70000
`define LTF_CLK_NS 8
`define LTF_STEPS 63
`define LTF_LAST_IDX 6'h3e
`define LTF_FULL_SCALE 10'h3e8
`define LTF_FAULT_DIV 5
`endif

// >>> hdl/ltf_pkg.sv
package ltf_pkg;
    // one-hot channel state
    typedef enum logic [3:0] {
        LTF_OFF = 4'b0001,
        LTF_UP = 4'b0010,
        LTF_ON = 4'b0100,
        LTF_DOWN = 4'b1000
    } ltf_state_t;
    typedef logic [5:0] ltf_idx_t;
    typedef logic [9:0] ltf_level_t;
endpackage : ltf_pkg

// >>> hdl/ltf_gamma_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ltf_gamma_if;
    logic [5:0] idx;
    logic [9:0] level;
    modport rom (input idx, output level);
    modport user (output idx, input level);
endinterface : ltf_gamma_if
`default_nettype wire

// >>> hdl/ltf_gamma_rom.sv
`timescale 1ns/100ps
`default_nettype none
`include "ltf_regs.svh"
module ltf_gamma_rom
    import ltf_pkg::*;
(
    input wire logic mclk_i,
    ltf_gamma_if.rom port_io
);
    // gamma curve, per mille of full scale
    localparam logic [9:0] TABLE [0:62] = '{
        10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
        10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
        10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
        10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180,
        10'd194, 10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282,
        10'd300, 10'd318, 10'd336, 10'd354, 10'd372, 10'd394, 10'd416,
        10'd438, 10'd460, 10'd482, 10'd504, 10'd534, 10'd564, 10'd594,
        10'd624, 10'd654, 10'd684, 10'd722, 10'd760, 10'd798, 10'd836,
        10'd874, 10'd914, 10'd956, 10'd1000
    };
    ltf_level_t level_q;

    // registered table read
    always_ff @(posedge mclk_i)
    begin
        if (port_io.idx > `LTF_LAST_IDX)
            level_q <= `LTF_FULL_SCALE;
        else
            level_q <= TABLE[port_io.idx];
    end
    assign port_io.level = level_q;
endmodule : ltf_gamma_rom
`default_nettype wire

// >>> tb/ltf_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
// push button that chatters for a few cycles on every change of command
module ltf_switch_model
(
    input wire logic mclk_i,
    input wire logic press_i,
    output logic toggle_n_o
);
    logic cmd_q = 1'b0;
    logic [1:0] bounce_q = 2'h0;
    // three chattering cycles after each change, then the level settles
    always @(posedge mclk_i)
    begin
        cmd_q <= press_i;
        if (press_i != cmd_q)
            bounce_q <= 2'h3;
        else if (bounce_q != 2'h0)
            bounce_q <= bounce_q - 2'h1;
    end
    // released contact reads as the pulled-up high level
    assign toggle_n_o = (bounce_q != 2'h0) ? bounce_q[0] : !cmd_q;
endmodule : ltf_switch_model
`default_nettype wire

// >>> tb/ltf_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module ltf_top_test;
    import ltf_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic press = 1'b0;
    logic toggle_n;
    logic pwm = 1'b0;
    logic short_det = 1'b0;
    logic supply_low = 1'b0;
    ltf_level_t level;
    logic latched;
    logic fault;
    logic pwm_mode;
    int miscompares = 0;
    int checks = 0;
    // 125 MHz clock
    always #4 mclk_i = ~mclk_i;
    ltf_switch_model i_ltf_switch_model (.mclk_i(mclk_i), .press_i(press),
        .toggle_n_o(toggle_n));
    // short windows keep the run brief; instant fades (138 cycles a step)
    ltf_top #(.DEBOUNCE_CYC(20), .FAULT_CYC(10)) i_ltf_top (
        .mclk_i(mclk_i), .reset_i(reset_i), .toggle_n_i(toggle_n),
        .pwm_i(pwm), .short_detect_i(short_det), .supply_low_i(supply_low),
        .fade_in_time_set_i(12'h000), .fade_out_time_set_i(12'h000),
        .drive_level_o(level), .latched_on_o(latched), .fault_o(fault),
        .pwm_mode_o(pwm_mode));
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_lvl(input ltf_level_t got, input ltf_level_t exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t level %0d expected %0d", $time, got, exp);
        end
    endtask : chk_lvl
    // bounded waits; running out of cycles is a miscompare and ends the run
    task automatic wait_lvl(input ltf_level_t exp, input int n);
        for (int i = 0; i < n && level !== exp; i++)
            step(1);
        chk_lvl(level, exp);
        if (level !== exp)
            stop_test();
    endtask : wait_lvl
    // waits on the fault flag when use_fault is set, else on the latch
    task automatic wait_bit(input bit use_fault, input logic exp, input int n);
        for (int i = 0; i < n && (use_fault ? fault : latched) !== exp; i++)
            step(1);
        chk_bit(use_fault ? fault : latched, exp);
        if ((use_fault ? fault : latched) !== exp)
            stop_test();
    endtask : wait_bit
    // full press and release, each held past the window
    task automatic push(input logic exp);
        press = 1'b1;
        wait_bit(1'b0, exp, 60);
        press = 1'b0;
        step(40);
    endtask : push
    task automatic t_glitch();
        press = 1'b1;
        step(15);
        press = 1'b0;
        step(60);
        chk_bit(latched, 1'b0);
    endtask : t_glitch
    task automatic t_pwm();
        pwm = 1'b1;
        wait_lvl(10'h3e8, 10);
        chk_bit(pwm_mode, 1'b1);
        pwm = 1'b0;
        wait_lvl(10'h000, 10);
    endtask : t_pwm
    task automatic t_on_over_pwm();
        pwm = 1'b1;
        push(1'b1);
        // 138 cycles a step: step 61 stands 8419 to 8557 cycles after latch
        step(8400);
        chk_lvl(level, 10'h3bc);
        wait_lvl(10'h3e8, 10000);
        chk_bit(pwm_mode, 1'b0);
        pwm = 1'b0;
        step(10);
        chk_lvl(level, 10'h3e8);
    endtask : t_on_over_pwm
    task automatic t_fault();
        short_det = 1'b1;
        step(8);
        chk_bit(fault, 1'b0);
        wait_bit(1'b1, 1'b1, 10);
        wait_lvl(10'h0c8, 5);
        short_det = 1'b0;
        wait_lvl(10'h3e8, 10);
        chk_bit(fault, 1'b0);
    endtask : t_fault
    // brief release while held must not count as release and re-press
    task automatic t_release();
        press = 1'b1;
        wait_bit(1'b0, 1'b1, 60);
        press = 1'b0;
        step(10);
        press = 1'b1;
        step(40);
        chk_bit(latched, 1'b1);
        press = 1'b0;
        step(40);
        push(1'b0);
        wait_lvl(10'h000, 3000);
    endtask : t_release
    task automatic t_reverse();
        push(1'b1);
        step(1000);
        chk_bit(level != 10'h000, 1'b1);
        push(1'b0);
        wait_lvl(10'h000, 3000);
    endtask : t_reverse
    task automatic t_supply();
        push(1'b1);
        step(1000);
        supply_low = 1'b1;
        step(5);
        chk_bit(latched, 1'b0);
        wait_lvl(10'h000, 10);
        supply_low = 1'b0;
        step(5);
    endtask : t_supply
    // main sequence
    initial
    begin
        step(10);
        reset_i = 1'b0;
        step(3);
        chk_bit(latched, 1'b0);
        chk_lvl(level, 10'h000);
        t_glitch();
        t_pwm();
        t_on_over_pwm();
        t_fault();
        push(1'b0);
        wait_lvl(10'h000, 10000);
        t_release();
        t_reverse();
        t_supply();
        stop_test();
    end
endmodule : ltf_top_test
`default_nettype wire
